// *** hdl/fsk_modem_regs.svh ***
`ifndef FSK_MODEM_REGS_SVH
`define FSK_MODEM_REGS_SVH

// Register word indices; byte address is four times the index
`define CFG_IDX 8'h88
`define PRE_IDX 8'h89
`define TMR_IDX 8'h8A
`define RTS_IDX 8'h8B

`define CFG_RESET 16'h0C30
`define CFG_WMASK 16'h3FFF
`define PRE_RESET 5'h05
`define PRE_W 5

// Configuration field positions
`define CFG_DUAL_PRE 12
`define CFG_WATCH 8
`define CFG_TRIG_HI 7
`define CFG_TRIG_LO 6
`define CFG_DELAY 5
`define CFG_AUTO 4
`define CFG_EDGE_HI 3
`define CFG_EDGE_LO 2
`define CFG_DUPLEX 1
`define CFG_POWER 0

// Control register of send request
`define RTS_BIT 0
`define RTS_BUSY_BIT 1
`define RTS_CD_BIT 2

`define PREAMBLE_BYTE 8'hFF
`define TIMER_MAX 16'hFFFF

// Timing
`define CLK_HZ 40000000
`define CLK_NS 25
`define BAUD 1200
`define TICK_NS 3255
`define BIT_CYCLES ((`CLK_HZ + `BAUD - 1) / `BAUD)
`define TICK_CYCLES (`TICK_NS / `CLK_NS)

`endif

// *** hdl/fsk_modem_pkg.sv ***
`default_nettype none
package fsk_modem_pkg;
  typedef enum logic [1:0] {
    TRIG_EOM = 2'b00,
    TRIG_SOM = 2'b01,
    TRIG_TXDONE = 2'b10,
    TRIG_CD = 2'b11
  } trig_sel_t;

  typedef enum logic [1:0] {
    EDGE_FALL = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_ANY = 2'b10,
    EDGE_OFF = 2'b11
  } edge_sel_t;

  typedef enum logic [1:0] {
    RX_HUNT = 2'b01,
    RX_FRAME = 2'b10
  } rx_state_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_WAIT = 5'b00010,
    TX_PRE = 5'b00100,
    TX_DATA = 5'b01000,
    TX_DONE = 5'b10000
  } tx_state_t;
endpackage : fsk_modem_pkg
`default_nettype wire

// *** hdl/elapsed_event_timer.sv ***
`include "fsk_modem_regs.svh"
`default_nettype none
module elapsed_event_timer #(
  parameter int WIDTH = 16,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic start,
  output logic [WIDTH-1:0] count
);
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [WIDTH-1:0] CMAX = {WIDTH{1'b1}};

  logic [TW-1:0] tick_r, tick_nxt;
  logic [WIDTH-1:0] count_r, count_nxt;
  logic run_r, run_nxt;

  always_comb begin
    tick_nxt = tick_r;
    count_nxt = count_r;
    run_nxt = run_r;
    if (clear) begin
      tick_nxt = '0;
      count_nxt = '0;
      run_nxt = 1'b0;
    end else if (start) begin
      tick_nxt = '0;
      count_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r) begin
      if (tick_r == TICK_LAST) begin
        tick_nxt = '0;
        // Saturate and hold until the next event
        if (count_r != CMAX) begin
          count_nxt = count_r + 1'b1;
        end
      end else begin
        tick_nxt = tick_r + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_r <= '0;
      count_r <= '0;
      run_r <= 1'b0;
    end else if (ce) begin
      tick_r <= tick_nxt;
      count_r <= count_nxt;
      run_r <= run_nxt;
    end
  end

  assign count = count_r;
endmodule : elapsed_event_timer
`default_nettype wire

// *** hdl/fsk_modem_frame_tx_config.sv ***
`include "fsk_modem_regs.svh"
`default_nettype none
module fsk_modem_frame_tx_config #(
  parameter int BIT_CYCLES = `BIT_CYCLES,
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic carrier_detect,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_msg_end,
  output logic rx_fifo_push,
  output logic [7:0] rx_fifo_data,
  input wire logic tx_fifo_empty,
  input wire logic [7:0] tx_fifo_data,
  output logic tx_fifo_pop,
  output logic tx_char_valid,
  output logic [7:0] tx_char_data,
  input wire logic tx_char_ready,
  input wire logic tx_line_busy,
  output logic send_request,
  output logic modem_power_on,
  output logic modem_duplex,
  output logic [15:0] event_elapsed_timer
);
  import fsk_modem_pkg::*;

  localparam int BW = $clog2(BIT_CYCLES + 1);
  localparam logic [BW-1:0] BIT_LAST = BW'(BIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: address phase captured, write applied in the data phase

  logic pend_r, pend_nxt;
  logic pwr_r, pwr_nxt;
  logic [7:0] pidx_r, pidx_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [`PRE_W-1:0] pre_r, pre_nxt;
  logic rts_r, rts_nxt;
  logic take;
  logic wr_en;
  logic tx_done;
  logic tx_busy;
  logic cd_s2;
  logic [7:0] aidx;

  assign take = hsel && htrans[1] && hready;
  assign aidx = haddr[9:2];
  assign wr_en = pend_r && pwr_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  always_comb begin
    pend_nxt = take;
    pwr_nxt = take && hwrite;
    pidx_nxt = take ? aidx : pidx_r;
    rdata_nxt = rdata_r;
    if (take && !hwrite) begin
      rdata_nxt = '0;
      if (haddr[31:10] != '0) begin
        rdata_nxt = '0;
      end else if (aidx == `CFG_IDX) begin
        rdata_nxt = {16'h0000, cfg_r};
      end else if (aidx == `PRE_IDX) begin
        rdata_nxt = {27'h000_0000, pre_r};
      end else if (aidx == `TMR_IDX) begin
        rdata_nxt = {16'h0000, event_elapsed_timer};
      end else if (aidx == `RTS_IDX) begin
        rdata_nxt[`RTS_BIT] = rts_r;
        rdata_nxt[`RTS_BUSY_BIT] = tx_busy;
        rdata_nxt[`RTS_CD_BIT] = cd_s2;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pwr_r <= 1'b0;
      pidx_r <= '0;
      rdata_r <= '0;
    end else if (ce) begin
      pend_r <= pend_nxt;
      pwr_r <= pwr_nxt;
      pidx_r <= pidx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration, preamble count and send request registers

  always_comb begin
    cfg_nxt = cfg_r;
    pre_nxt = pre_r;
    rts_nxt = rts_r;
    if (tx_done && cfg_r[`CFG_AUTO]) begin
      rts_nxt = 1'b0;
    end
    // A software write lands after the automatic release
    if (wr_en && pidx_r == `CFG_IDX) begin
      cfg_nxt = hwdata[15:0] & `CFG_WMASK;
    end else if (wr_en && pidx_r == `PRE_IDX) begin
      pre_nxt = hwdata[`PRE_W-1:0];
    end else if (wr_en && pidx_r == `RTS_IDX) begin
      rts_nxt = hwdata[`RTS_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= `CFG_RESET;
      pre_r <= `PRE_RESET;
      rts_r <= 1'b0;
    end else if (ce) begin
      cfg_r <= cfg_nxt;
      pre_r <= pre_nxt;
      rts_r <= rts_nxt;
    end
  end

  assign send_request = rts_r;
  assign modem_power_on = cfg_r[`CFG_POWER];
  assign modem_duplex = cfg_r[`CFG_DUPLEX];

  ////////////////////////////////////////////////////////////////////////////
  // Carrier detect synchroniser and edge selection

  logic cd_s1, cd_prev;
  logic cd_edge;
  edge_sel_t esel;

  assign esel = edge_sel_t'(cfg_r[`CFG_EDGE_HI:`CFG_EDGE_LO]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cd_s1 <= 1'b0;
      cd_s2 <= 1'b0;
      cd_prev <= 1'b0;
    end else if (ce) begin
      cd_s1 <= carrier_detect;
      cd_s2 <= cd_s1;
      cd_prev <= cd_s2;
    end
  end

  always_comb begin
    case (esel)
      EDGE_FALL: cd_edge = cd_prev && !cd_s2;
      EDGE_RISE: cd_edge = !cd_prev && cd_s2;
      EDGE_ANY: cd_edge = cd_prev != cd_s2;
      default: cd_edge = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive frame monitor

  rx_state_t rx_r, rx_nxt;
  logic [1:0] pcnt_r, pcnt_nxt;
  logic push_r, push_nxt;
  logic [7:0] rxd_r, rxd_nxt;
  logic start_of_message, end_of_message;
  logic [1:0] need;
  logic watch;

  assign watch = cfg_r[`CFG_WATCH];
  assign need = cfg_r[`CFG_DUAL_PRE] ? 2'd2 : 2'd1;

  always_comb begin
    rx_nxt = rx_r;
    pcnt_nxt = pcnt_r;
    push_nxt = 1'b0;
    rxd_nxt = rxd_r;
    start_of_message = 1'b0;
    end_of_message = 1'b0;
    if (!watch) begin
      rx_nxt = RX_HUNT;
      pcnt_nxt = '0;
      push_nxt = rx_char_valid;
      if (rx_char_valid) begin
        rxd_nxt = rx_char_data;
      end
    end else begin
      case (rx_r)
        RX_HUNT: begin
          if (rx_char_valid && rx_char_data == `PREAMBLE_BYTE) begin
            if (pcnt_r != 2'd2) begin
              pcnt_nxt = pcnt_r + 2'd1;
            end
          end else if (rx_char_valid && pcnt_r >= need) begin
            // Delimiter opens the frame; preambles were never pushed
            push_nxt = 1'b1;
            rxd_nxt = rx_char_data;
            start_of_message = 1'b1;
            pcnt_nxt = '0;
            rx_nxt = RX_FRAME;
          end else if (rx_char_valid) begin
            pcnt_nxt = '0;
          end
        end
        RX_FRAME: begin
          if (rx_msg_end) begin
            end_of_message = 1'b1;
            rx_nxt = RX_HUNT;
          end else if (rx_char_valid) begin
            push_nxt = 1'b1;
            rxd_nxt = rx_char_data;
          end
        end
        default: rx_nxt = RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_r <= RX_HUNT;
      pcnt_r <= '0;
      push_r <= 1'b0;
      rxd_r <= '0;
    end else if (ce) begin
      rx_r <= rx_nxt;
      pcnt_r <= pcnt_nxt;
      push_r <= push_nxt;
      rxd_r <= rxd_nxt;
    end
  end

  assign rx_fifo_push = push_r && ce;
  assign rx_fifo_data = rxd_r;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencer

  tx_state_t tx_r, tx_nxt;
  logic [BW-1:0] wcnt_r, wcnt_nxt;
  logic [`PRE_W-1:0] pleft_r, pleft_nxt;
  logic tv_r, tv_nxt;
  logic [7:0] td_r, td_nxt;
  logic pop;

  assign tx_busy = tx_r != TX_IDLE;
  assign tx_done = tx_r == TX_DONE;

  always_comb begin
    tx_nxt = tx_r;
    wcnt_nxt = wcnt_r;
    pleft_nxt = pleft_r;
    tv_nxt = tv_r;
    td_nxt = td_r;
    pop = 1'b0;
    if (tv_r && tx_char_ready) begin
      tv_nxt = 1'b0;
    end
    case (tx_r)
      TX_IDLE: begin
        wcnt_nxt = '0;
        pleft_nxt = pre_r;
        if (!tx_fifo_empty && modem_power_on) begin
          if (!cfg_r[`CFG_DELAY]) begin
            tx_nxt = (pre_r == '0) ? TX_DATA : TX_PRE;
          end else if (rts_r) begin
            tx_nxt = TX_WAIT;
          end
        end
      end
      TX_WAIT: begin
        wcnt_nxt = wcnt_r + 1'b1;
        if (!rts_r) begin
          tx_nxt = TX_IDLE;
        end else if (wcnt_r == BIT_LAST) begin
          tx_nxt = (pre_r == '0) ? TX_DATA : TX_PRE;
        end
      end
      TX_PRE: begin
        if (!tv_r && pleft_r != '0) begin
          tv_nxt = 1'b1;
          td_nxt = `PREAMBLE_BYTE;
          pleft_nxt = pleft_r - 1'b1;
        end else if (!tv_r) begin
          tx_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        if (!tv_r && !tx_fifo_empty) begin
          pop = 1'b1;
          tv_nxt = 1'b1;
          td_nxt = tx_fifo_data;
        end else if (!tv_r && !tx_line_busy) begin
          tx_nxt = TX_DONE;
        end
      end
      TX_DONE: tx_nxt = TX_IDLE;
      default: tx_nxt = TX_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_r <= TX_IDLE;
      wcnt_r <= '0;
      pleft_r <= '0;
      tv_r <= 1'b0;
      td_r <= '0;
    end else if (ce) begin
      tx_r <= tx_nxt;
      wcnt_r <= wcnt_nxt;
      pleft_r <= pleft_nxt;
      tv_r <= tv_nxt;
      td_r <= td_nxt;
    end
  end

  assign tx_fifo_pop = pop && ce;
  assign tx_char_valid = tv_r;
  assign tx_char_data = td_r;

  ////////////////////////////////////////////////////////////////////////////
  // Elapsed-event timer trigger

  logic ev_start;
  trig_sel_t tsel;

  assign tsel = trig_sel_t'(cfg_r[`CFG_TRIG_HI:`CFG_TRIG_LO]);

  always_comb begin
    case (tsel)
      TRIG_EOM: ev_start = end_of_message;
      TRIG_SOM: ev_start = start_of_message;
      TRIG_TXDONE: ev_start = tx_done;
      default: ev_start = cd_edge;
    endcase
  end

  elapsed_event_timer #(
    .WIDTH(16),
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .clear(!watch),
    .start(ev_start),
    .count(event_elapsed_timer)
  );
endmodule : fsk_modem_frame_tx_config
`default_nettype wire

// *** bench/fsk_modem_frame_tx_config_props.sv ***
`default_nettype none
module fsk_modem_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic rx_char_valid,
  input wire logic [7:0] rx_char_data,
  input wire logic rx_fifo_push,
  input wire logic [7:0] rx_fifo_data,
  input wire logic tx_fifo_empty,
  input wire logic [7:0] tx_fifo_data,
  input wire logic tx_fifo_pop,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  input wire logic tx_char_ready,
  input wire logic modem_power_on,
  input wire logic [15:0] event_elapsed_timer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_ready;
    hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus slave not ready or not okay");
  property p_push;
    rx_fifo_push |-> $past(rx_char_valid) && rx_fifo_data == $past(rx_char_data);
  endproperty
  a_push: assert property (p_push) else $error("stored byte differs from received byte");
  property p_pop;
    tx_fifo_pop |-> !tx_fifo_empty && modem_power_on;
  endproperty
  a_pop: assert property (p_pop) else $error("pop from empty fifo or while powered down");
  property p_popval;
    tx_fifo_pop |=> tx_char_valid && tx_char_data == $past(tx_fifo_data);
  endproperty
  a_popval: assert property (p_popval) else $error("popped word not offered to uart");
  property p_hold;
    tx_char_valid && !tx_char_ready |=> tx_char_valid && $stable(tx_char_data);
  endproperty
  a_hold: assert property (p_hold) else $error("char dropped before acceptance");
  property p_pwr;
    $rose(tx_char_valid) |-> modem_power_on;
  endproperty
  a_pwr: assert property (p_pwr) else $error("char sent while powered down");
  property p_sat;
    event_elapsed_timer == 16'hFFFF |=> event_elapsed_timer inside {16'hFFFF, 16'h0000};
  endproperty
  a_sat: assert property (p_sat) else $error("timer left saturation");
  property p_step;
    $changed(event_elapsed_timer) |-> event_elapsed_timer == 16'h0000 ||
      event_elapsed_timer == $past(event_elapsed_timer) + 16'h0001;
  endproperty
  a_step: assert property (p_step) else $error("timer jumped");
endmodule : fsk_modem_checker

bind fsk_modem_frame_tx_config fsk_modem_checker i_chk (.*);
`default_nettype wire

// *** bench/uart_partner.sv ***
`default_nettype none
module uart_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [3:0] gap,
  input wire logic tx_char_valid,
  input wire logic [7:0] tx_char_data,
  output logic tx_char_ready,
  output logic tx_line_busy,
  output logic [7:0] n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [0:31];
  logic [3:0] cnt;
  assign tx_char_ready = (cnt == 4'h0);
  assign tx_line_busy = (cnt != 4'h0);
  // Each accepted char keeps the line busy for gap+1 cycles
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      n <= 8'h00;
    end else if (cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (tx_char_valid) begin
      got[n[4:0]] <= tx_char_data;
      n <= n + 8'h01;
      cnt <= gap + 4'h1;
    end
  end
endmodule : uart_partner
`default_nettype wire

// *** bench/tb_top.sv ***
`include "fsk_modem_regs.svh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, carrier_detect, rx_char_valid, rx_msg_end;
  logic [31:0] haddr, hwdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rx_char_data, fq [0:15], rq [0:15];
  logic [3:0] rp, wp, rn, gap;
  logic [55:0] s;
  wire logic hready, hreadyout, hresp, rx_fifo_push, tx_fifo_empty, tx_fifo_pop, tx_char_valid;
  wire logic tx_char_ready, tx_line_busy, send_request, modem_power_on, modem_duplex;
  wire logic [31:0] hrdata;
  wire logic [7:0] rx_fifo_data, tx_fifo_data, tx_char_data, n;
  wire logic [15:0] event_elapsed_timer;
  int mismatches, num_checks, cyc, i, e;
  assign hready = hreadyout;
  assign tx_fifo_empty = (rp == wp);
  assign tx_fifo_data = fq[rp];

  fsk_modem_frame_tx_config #(.BIT_CYCLES(20), .TICK_CYCLES(4)) i_dut (.hclk, .hresetn, .ce(1'b1),
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .carrier_detect, .rx_char_valid, .rx_char_data, .rx_msg_end, .rx_fifo_push, .rx_fifo_data,
    .tx_fifo_empty, .tx_fifo_data, .tx_fifo_pop, .tx_char_valid, .tx_char_data, .tx_char_ready,
    .tx_line_busy, .send_request, .modem_power_on, .modem_duplex, .event_elapsed_timer);
  uart_partner i_uart (.hclk, .hresetn, .gap, .tx_char_valid, .tx_char_data, .tx_char_ready,
    .tx_line_busy, .n);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit fifo and receive sink
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (!hresetn) begin
      rp <= 4'h0;
      rn <= 4'h0;
    end else begin
      if (tx_fifo_pop)
        rp <= rp + 4'h1;
      if (rx_fifo_push) begin
        rq[rn] <= rx_fifo_data;
        rn <= rn + 4'h1;
      end
    end
  end

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'h0};
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge hclk);
    while (!hready) @(posedge hclk);
    rv = hrdata;
  endtask : bus

  task push(input logic [7:0] d);
    fq[wp] <= d;
    wp <= wp + 4'h1;
    @(posedge hclk);
  endtask : push

  task rxb(input logic [7:0] d);
    rx_char_valid <= 1'b1;
    rx_char_data <= d;
    @(posedge hclk);
    rx_char_valid <= 1'b0;
    repeat (2) @(posedge hclk);
  endtask : rxb

  task endmsg;
    rx_msg_end <= 1'b1;
    @(posedge hclk);
    rx_msg_end <= 1'b0;
    @(posedge hclk);
  endtask : endmsg

  task waitn(input logic [7:0] k);
    for (i = 0; i < 300 && n < k; i++) @(posedge hclk);
    chk(n, k);
  endtask : waitn

  task age;
    repeat (40) @(posedge hclk);
  endtask : age

  // Timer near zero means the last event restarted it; the wait covers the
  // synchroniser delay and the cycle between line idle and the done event
  task tmr(input logic x);
    repeat (12) @(posedge hclk);
    chk(event_elapsed_timer < 16'h0004, x);
  endtask : tmr

  initial begin
    repeat (30000) @(posedge hclk);
    mismatches++;
    report_and_stop;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, carrier_detect, rx_char_valid, rx_msg_end, htrans} = '0;
    {haddr, hwdata, rx_char_data, wp} = '0;
    hsize = 3'h2;
    gap = 4'h2;
    cyc = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, `CFG_IDX, 0);
    chk(rv, {16'h0, `CFG_RESET});
    bus(1'b0, `PRE_IDX, 0);
    chk(rv, 32'h5);
    chk(modem_power_on, 1'b0);
    bus(1'b0, 8'h90, 0);
    chk(rv, 32'h0);
    bus(1'b1, `PRE_IDX, 32'hFFFF);
    bus(1'b0, `PRE_IDX, 0);
    chk(rv, 32'h1F);
    bus(1'b1, `PRE_IDX, 32'h2);
    bus(1'b1, `CFG_IDX, 32'h10);
    push(8'hA1);
    repeat (30) @(posedge hclk);
    chk(n, 8'h0);
    bus(1'b1, `CFG_IDX, 32'h13);
    push(8'hB2);
    chk(modem_duplex, 1'b1);
    waitn(4);
    chk({i_uart.got[0], i_uart.got[1], i_uart.got[2], i_uart.got[3]}, 32'hFFFF_A1B2);
    chk(send_request, 1'b0);
    bus(1'b1, `PRE_IDX, 32'h0);
    gap <= 4'h6;
    push(8'hC3);
    waitn(5);
    repeat (20) @(posedge hclk);
    chk({n, i_uart.got[4]}, 16'h05C3);
    bus(1'b1, `CFG_IDX, 32'h31);
    push(8'hD4);
    repeat (40) @(posedge hclk);
    chk(n, 8'h5);
    bus(1'b1, `RTS_IDX, 32'h1);
    e = cyc;
    waitn(6);
    chk(cyc - e >= 20, 1'b1);
    for (i = 0; i < 40 && send_request; i++) @(posedge hclk);
    bus(1'b0, `RTS_IDX, 0);
    chk({send_request, rv[0]}, 2'h0);
    bus(1'b1, `CFG_IDX, 32'h21);
    bus(1'b1, `RTS_IDX, 32'h1);
    push(8'hE5);
    waitn(7);
    repeat (20) @(posedge hclk);
    chk(send_request, 1'b1);
    bus(1'b1, `RTS_IDX, 32'h0);
    repeat (2) @(posedge hclk);
    chk(send_request, 1'b0);
    rxb(8'h55);
    bus(1'b1, `CFG_IDX, 32'h1101);
    s = 56'h82_FF11_FFFF_8233;
    for (e = 0; e < 7; e++) rxb(s[55-8*e -: 8]);
    chk(rn, 4'h3);
    chk({rq[0], rq[1], rq[2]}, 24'h55_8233);
    endmsg;
    bus(1'b1, `CFG_IDX, 32'h0101);
    rxb(8'hFF);
    rxb(8'h66);
    chk(rq[3], 8'h66);
    age;
    endmsg;
    tmr(1'b1);
    bus(1'b1, `CFG_IDX, 32'h0141);
    age;
    rxb(8'hFF);
    rxb(8'h77);
    tmr(1'b1);
    age;
    endmsg;
    tmr(1'b0);
    bus(1'b1, `CFG_IDX, 32'h0181);
    age;
    push(8'hF6);
    waitn(8);
    tmr(1'b1);
    for (e = 0; e < 4; e++) begin
      bus(1'b1, `CFG_IDX, 32'h01C1 | (e << 2));
      age;
      carrier_detect <= 1'b1;
      tmr(e == 1 || e == 2);
      age;
      carrier_detect <= 1'b0;
      tmr(e == 0 || e == 2);
    end
    bus(1'b1, `CFG_IDX, 32'h1);
    repeat (4) @(posedge hclk);
    chk(event_elapsed_timer, 16'h0);
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
